// >>> verilog/tdmrx_receiver.sv
/*
 * receive side of a serial port slaved to a single-rate tdm telecom bus,
 * with register port, sticky interrupts and a dma read event per word.
 * assumes: bit clock, frame pulse and data come from the bus device and are
 * asynchronous to sys_clk, which is at least eight times faster.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tdmrx_cfg.svh"

module tdmrx_receiver (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic ext_clock_pin,
   input wire logic recv_sync_pin,
   input wire logic serial_data_in,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic cpu_irq_line_fifteen,
   output logic recv_dma_event,
   output logic recv_clock_pin_o,
   output logic recv_clock_pin_oe,
   output logic recv_sync_pin_o,
   output logic recv_sync_pin_oe
);

   logic [2:0] pin_s;
   logic clk_prev_reg, clk_prev_next;
   logic sync_prev_reg, sync_prev_next;
   logic [31:0] recv_control_reg, recv_control_next;
   logic [31:0] port_control_reg, port_control_next;
   logic [31:0] rate_gen_reg, rate_gen_next;
   logic [31:0] pin_control_reg, pin_control_next;
   logic [15:0] frame_target_reg, frame_target_next;
   logic [`TDMRX_IRQ_W-1:0] irq_status_reg, irq_status_next;
   logic [`TDMRX_IRQ_W-1:0] irq_enable_reg, irq_enable_next;
   logic [31:0] rdata_reg, rdata_next;
   logic irq_reg, irq_next;
   logic clk_o_reg, clk_o_next;
   logic clk_oe_reg, clk_oe_next;
   logic sync_oe_reg, sync_oe_next;
   logic internal_recv_sync_reg, internal_recv_sync_next;
   tdmrx_pkg::tdmrx_state_type state_reg, state_next;
   logic [6:0] elem_cnt_reg, elem_cnt_next;
   logic [5:0] bit_cnt_reg, bit_cnt_next;
   logic [1:0] dly_cnt_reg, dly_cnt_next;
   logic [31:0] shift_reg, shift_next;
   logic [31:0] recv_data_reg, recv_data_next;
   logic data_full_reg, data_full_next;
   logic dma_reg, dma_next;
   logic [15:0] frame_cnt_reg, frame_cnt_next;
   logic word_done, overrun_evt, done_evt, rise, fall, active_edge, frame_level;
   logic frame_start, data_read;
   logic [`TDMRX_IRQ_W-1:0] irq_evt;

   wire logic ext_sync_lock = rate_gen_reg[`TDMRX_RG_EXT_LOCK];
   wire logic edge_sel = rate_gen_reg[`TDMRX_RG_EDGE_SEL];
   wire logic rate_gen_reset_n = port_control_reg[`TDMRX_PC_RATE_GEN_RST];
   wire logic sync_gen_reset_n = port_control_reg[`TDMRX_PC_SYNC_GEN_RST];
   wire logic recv_reset_n = port_control_reg[`TDMRX_PC_RECV_RST];
   wire logic [1:0] recv_irq_select =
      port_control_reg[`TDMRX_PC_IRQ_SEL_HI:`TDMRX_PC_IRQ_SEL_LO];
   wire logic recv_sync_source_sel = pin_control_reg[`TDMRX_PN_SYNC_SRC];
   wire logic recv_clock_dir = pin_control_reg[`TDMRX_PN_CLK_DIR];
   wire logic recv_sync_polarity = pin_control_reg[`TDMRX_PN_SYNC_POL];
   wire logic [1:0] recv_data_delay =
      recv_control_reg[`TDMRX_RC_DLY_HI:`TDMRX_RC_DLY_LO];
   wire logic [6:0] phase1_frame_length =
      recv_control_reg[`TDMRX_RC_FRLEN_HI:`TDMRX_RC_FRLEN_LO];
   wire logic [2:0] phase1_word_length =
      recv_control_reg[`TDMRX_RC_WDLEN_HI:`TDMRX_RC_WDLEN_LO];
   wire logic [5:0] word_bits = tdmrx_pkg::tdmrx_word_bits(phase1_word_length);

   // all three bus pins are inputs and pass two flops first
   tdmrx_pin_sync #(.WIDTH(3)) u_pin_sync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .pins_in({serial_data_in, recv_sync_pin, ext_clock_pin}),
      .pins_out(pin_s)
   );

   // edge finder and frame sync sampler on the external bit clock
   always_comb begin
      rise = pin_s[0] & ~clk_prev_reg;
      fall = ~pin_s[0] & clk_prev_reg;
      active_edge = rate_gen_reset_n & (edge_sel ? fall : rise);
      frame_level = pin_s[1] ^ recv_sync_polarity;
      // only the pulse itself marks a frame; nothing counts the period
      frame_start = active_edge & frame_level & ~sync_prev_reg & ext_sync_lock
         & sync_gen_reset_n & recv_sync_source_sel;
      clk_prev_next = pin_s[0];
      sync_prev_next = active_edge ? frame_level : sync_prev_reg;
      internal_recv_sync_next = frame_start ? 1'b1 :
         (active_edge ? 1'b0 : internal_recv_sync_reg);
      clk_o_next = pin_s[0] ^ edge_sel;
      clk_oe_next = recv_clock_dir;
      sync_oe_next = recv_sync_source_sel & ~ext_sync_lock;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         clk_prev_reg <= 1'b0;
         sync_prev_reg <= 1'b0;
         internal_recv_sync_reg <= 1'b0;
         clk_o_reg <= 1'b0;
         clk_oe_reg <= 1'b0;
         sync_oe_reg <= 1'b0;
      end else if (clk_en) begin
         clk_prev_reg <= clk_prev_next;
         sync_prev_reg <= sync_prev_next;
         internal_recv_sync_reg <= internal_recv_sync_next;
         clk_o_reg <= clk_o_next;
         clk_oe_reg <= clk_oe_next;
         sync_oe_reg <= sync_oe_next;
      end
   end

   // receiver: element assembly, frame and word counting
   always_comb begin
      state_next = state_reg;
      elem_cnt_next = elem_cnt_reg;
      bit_cnt_next = bit_cnt_reg;
      dly_cnt_next = dly_cnt_reg;
      shift_next = shift_reg;
      recv_data_next = recv_data_reg;
      frame_cnt_next = frame_cnt_reg;
      dma_next = 1'b0;
      word_done = 1'b0;
      overrun_evt = 1'b0;
      done_evt = 1'b0;
      data_read = reg_rd & (reg_addr == `TDMRX_OFS_DATA);
      if (!recv_reset_n) begin
         state_next = tdmrx_pkg::ST_HALT;
         elem_cnt_next = 7'h00;
         bit_cnt_next = 6'h00;
         dly_cnt_next = 2'h0;
         shift_next = 32'h00000000;
         frame_cnt_next = 16'h0000;
      end else begin
         case (state_reg)
            tdmrx_pkg::ST_HALT: begin
               state_next = tdmrx_pkg::ST_WAIT;
            end
            tdmrx_pkg::ST_WAIT, tdmrx_pkg::ST_RUN: begin
               if (frame_start) begin
                  state_next = tdmrx_pkg::ST_RUN;
                  elem_cnt_next = 7'h00;
                  shift_next = 32'h00000000;
                  if (recv_data_delay == 2'h0) begin
                     shift_next = {31'h00000000, pin_s[2]};
                     bit_cnt_next = 6'h01;
                  end else begin
                     dly_cnt_next = recv_data_delay - 2'h1;
                     bit_cnt_next = 6'h00;
                  end
               end else if (state_reg == tdmrx_pkg::ST_RUN && active_edge) begin
                  if (dly_cnt_reg != 2'h0) begin
                     dly_cnt_next = dly_cnt_reg - 2'h1;
                  end else begin
                     shift_next = {shift_reg[30:0], pin_s[2]};
                     bit_cnt_next = bit_cnt_reg + 6'h01;
                     if (bit_cnt_reg + 6'h01 == word_bits) begin
                        word_done = 1'b1;
                     end
                  end
               end
               if (word_done) begin
                  recv_data_next = shift_next;
                  shift_next = 32'h00000000;
                  bit_cnt_next = 6'h00;
                  dma_next = 1'b1;
                  overrun_evt = data_full_reg & ~data_read;
                  if (elem_cnt_reg == phase1_frame_length) begin
                     frame_cnt_next = frame_cnt_reg + 16'h0001;
                     state_next = tdmrx_pkg::ST_WAIT;
                     if (frame_target_reg != 16'h0000 &&
                         frame_cnt_next == frame_target_reg) begin
                        state_next = tdmrx_pkg::ST_DONE;
                        done_evt = 1'b1;
                     end
                  end else begin
                     elem_cnt_next = elem_cnt_reg + 7'h01;
                  end
               end
            end
            tdmrx_pkg::ST_DONE: begin
               state_next = tdmrx_pkg::ST_DONE;
            end
            default: begin
               state_next = tdmrx_pkg::ST_HALT;
            end
         endcase
      end
      // a new word wins over the read that empties the register
      data_full_next = word_done ? 1'b1 : (data_read ? 1'b0 : data_full_reg);
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_reg <= tdmrx_pkg::ST_HALT;
         elem_cnt_reg <= 7'h00;
         bit_cnt_reg <= 6'h00;
         dly_cnt_reg <= 2'h0;
         shift_reg <= 32'h00000000;
         recv_data_reg <= 32'h00000000;
         data_full_reg <= 1'b0;
         dma_reg <= 1'b0;
         frame_cnt_reg <= 16'h0000;
      end else if (clk_en) begin
         state_reg <= state_next;
         elem_cnt_reg <= elem_cnt_next;
         bit_cnt_reg <= bit_cnt_next;
         dly_cnt_reg <= dly_cnt_next;
         shift_reg <= shift_next;
         recv_data_reg <= recv_data_next;
         data_full_reg <= data_full_next;
         dma_reg <= dma_next;
         frame_cnt_reg <= frame_cnt_next;
      end
   end

   // register port and interrupt status
   always_comb begin
      recv_control_next = recv_control_reg;
      port_control_next = port_control_reg;
      rate_gen_next = rate_gen_reg;
      pin_control_next = pin_control_reg;
      frame_target_next = frame_target_reg;
      irq_enable_next = irq_enable_reg;
      irq_evt = '0;
      // frame sync event counts even while the receiver is held in reset
      irq_evt[`TDMRX_IRQ_FSYNC] = frame_start
         & (recv_irq_select == `TDMRX_IRQSEL_FSYNC);
      irq_evt[`TDMRX_IRQ_WORD] = word_done & (recv_irq_select == `TDMRX_IRQSEL_WORD);
      irq_evt[`TDMRX_IRQ_OVERRUN] = overrun_evt;
      irq_evt[`TDMRX_IRQ_DONE] = done_evt;
      irq_status_next = irq_status_reg;
      if (reg_wr) begin
         case (reg_addr)
            `TDMRX_OFS_RECV_CTRL: recv_control_next = reg_wdata & `TDMRX_MASK_RECV_CTRL;
            `TDMRX_OFS_PORT_CTRL: port_control_next = reg_wdata & `TDMRX_MASK_PORT_CTRL;
            `TDMRX_OFS_RATE_GEN: rate_gen_next = reg_wdata & `TDMRX_MASK_RATE_GEN;
            `TDMRX_OFS_PIN_CTRL: pin_control_next = reg_wdata & `TDMRX_MASK_PIN_CTRL;
            `TDMRX_OFS_FRAME_TARGET: frame_target_next = reg_wdata[15:0];
            `TDMRX_OFS_IRQ_ENABLE: irq_enable_next = reg_wdata[`TDMRX_IRQ_W-1:0];
            `TDMRX_OFS_IRQ_CLEAR: begin
               irq_status_next = irq_status_reg & ~reg_wdata[`TDMRX_IRQ_W-1:0];
            end
            default: begin
            end
         endcase
      end
      irq_status_next = irq_status_next | irq_evt;
      irq_next = |(irq_status_reg & irq_enable_reg);
      rdata_next = 32'h00000000;
      if (reg_rd) begin
         case (reg_addr)
            `TDMRX_OFS_RECV_CTRL: rdata_next = recv_control_reg;
            `TDMRX_OFS_PORT_CTRL: begin
               rdata_next = port_control_reg;
               rdata_next[1] = data_full_reg;
            end
            `TDMRX_OFS_RATE_GEN: rdata_next = rate_gen_reg;
            `TDMRX_OFS_PIN_CTRL: rdata_next = pin_control_reg;
            `TDMRX_OFS_DATA: rdata_next = recv_data_reg;
            `TDMRX_OFS_IRQ_STATUS: rdata_next = {28'h0000000, irq_status_reg};
            `TDMRX_OFS_IRQ_ENABLE: rdata_next = {28'h0000000, irq_enable_reg};
            `TDMRX_OFS_FRAME_TARGET: rdata_next = {16'h0000, frame_target_reg};
            `TDMRX_OFS_FRAME_COUNT: rdata_next = {16'h0000, frame_cnt_reg};
            default: rdata_next = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         recv_control_reg <= `TDMRX_RST_RECV_CTRL;
         port_control_reg <= `TDMRX_RST_PORT_CTRL;
         rate_gen_reg <= `TDMRX_RST_RATE_GEN;
         pin_control_reg <= `TDMRX_RST_PIN_CTRL;
         frame_target_reg <= 16'h0000;
         irq_status_reg <= '0;
         irq_enable_reg <= '0;
         irq_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
      end else if (clk_en) begin
         recv_control_reg <= recv_control_next;
         port_control_reg <= port_control_next;
         rate_gen_reg <= rate_gen_next;
         pin_control_reg <= pin_control_next;
         frame_target_reg <= frame_target_next;
         irq_status_reg <= irq_status_next;
         irq_enable_reg <= irq_enable_next;
         irq_reg <= irq_next;
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign cpu_irq_line_fifteen = irq_reg;
   assign recv_dma_event = dma_reg;
   assign recv_clock_pin_o = clk_o_reg;
   assign recv_clock_pin_oe = clk_oe_reg;
   assign recv_sync_pin_o = internal_recv_sync_reg;
   assign recv_sync_pin_oe = sync_oe_reg;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   chk_sync_pin_quiet: assert property (clk_en && ext_sync_lock |=> !recv_sync_pin_oe)
      else $error("sync pin driven while sync lock set");
   chk_clock_pin_out: assert property (clk_en && recv_clock_dir |=> recv_clock_pin_oe)
      else $error("receive clock pin not driven");
   chk_sync_polarity: assert property (frame_start |-> (pin_s[1] != recv_sync_polarity))
      else $error("frame start on wrong pulse level");
   chk_edge_choice: assert property (frame_start |-> (edge_sel ? fall : rise))
      else $error("frame sync sampled on wrong edge");
   chk_sync_width: assert property (clk_en && frame_start |=>
      internal_recv_sync_reg throughout (!(clk_en && active_edge))[*1])
      else $error("internal sync not raised after frame start");
   chk_first_bit: assert property (clk_en && frame_start && recv_reset_n
      && (state_reg == tdmrx_pkg::ST_WAIT || state_reg == tdmrx_pkg::ST_RUN)
      && recv_data_delay == 2'h0
      |=> bit_cnt_reg == 6'h01 && shift_reg[0] == $past(pin_s[2]))
      else $error("first bit not taken with frame sync");
   chk_dma_word: assert property (clk_en && word_done |=> (recv_dma_event
      && recv_data_reg == $past(recv_data_next)) ##1 (!recv_dma_event || !clk_en))
      else $error("word without single dma event");
   chk_frame_end: assert property (clk_en && word_done && elem_cnt_reg == phase1_frame_length
      |=> state_reg != tdmrx_pkg::ST_RUN)
      else $error("frame runs past its last element");
   chk_fsync_irq: assert property (clk_en && frame_start
      && recv_irq_select == `TDMRX_IRQSEL_FSYNC |=> irq_status_reg[`TDMRX_IRQ_FSYNC])
      else $error("frame sync event lost");
   chk_irq_level: assert property (clk_en ##1 clk_en |->
      cpu_irq_line_fifteen == |($past(irq_status_reg) & $past(irq_enable_reg)))
      else $error("interrupt line disagrees with status");
   chk_frames_stop: assert property (clk_en && done_evt |=>
      state_reg == tdmrx_pkg::ST_DONE && frame_cnt_reg == frame_target_reg)
      else $error("receiver did not stop at frame target");

endmodule // tdmrx_receiver

`default_nettype wire

// >>> shared/tdmrx_cfg.svh
/*
 * register offsets, field positions, write masks and reset values of the
 * tdm serial frame receiver.
 * assumes: included by its bare name from the design files.
 */
`ifndef TDMRX_CFG_SVH
`define TDMRX_CFG_SVH

`define TDMRX_OFS_RECV_CTRL 8'h00
`define TDMRX_OFS_PORT_CTRL 8'h04
`define TDMRX_OFS_RATE_GEN 8'h08
`define TDMRX_OFS_PIN_CTRL 8'h0C
`define TDMRX_OFS_DATA 8'h10
`define TDMRX_OFS_IRQ_STATUS 8'h14
`define TDMRX_OFS_IRQ_CLEAR 8'h18
`define TDMRX_OFS_IRQ_ENABLE 8'h1C
`define TDMRX_OFS_FRAME_TARGET 8'h20
`define TDMRX_OFS_FRAME_COUNT 8'h24

// receive_control fields
`define TDMRX_RC_DLY_HI 17
`define TDMRX_RC_DLY_LO 16
`define TDMRX_RC_FRLEN_HI 14
`define TDMRX_RC_FRLEN_LO 8
`define TDMRX_RC_WDLEN_HI 7
`define TDMRX_RC_WDLEN_LO 5
// serial_port_control fields
`define TDMRX_PC_SYNC_GEN_RST 23
`define TDMRX_PC_RATE_GEN_RST 22
`define TDMRX_PC_IRQ_SEL_HI 5
`define TDMRX_PC_IRQ_SEL_LO 4
`define TDMRX_PC_RECV_RST 0
// sample_rate_gen fields
`define TDMRX_RG_EXT_LOCK 31
`define TDMRX_RG_EDGE_SEL 30
`define TDMRX_RG_SRC_SEL 29
`define TDMRX_RG_DIV_HI 7
`define TDMRX_RG_DIV_LO 0
// pin_control fields
`define TDMRX_PN_SYNC_SRC 10
`define TDMRX_PN_CLK_DIR 8
`define TDMRX_PN_SYNC_POL 2

`define TDMRX_MASK_RECV_CTRL 32'h00037FE0
`define TDMRX_MASK_PORT_CTRL 32'h00C00031
`define TDMRX_MASK_RATE_GEN 32'hE00000FF
`define TDMRX_MASK_PIN_CTRL 32'h00000504

`define TDMRX_RST_RECV_CTRL 32'h00000000
`define TDMRX_RST_PORT_CTRL 32'h00000000
`define TDMRX_RST_RATE_GEN 32'h00000000
`define TDMRX_RST_PIN_CTRL 32'h00000000

// interrupt status bits
`define TDMRX_IRQ_W 4
`define TDMRX_IRQ_FSYNC 0
`define TDMRX_IRQ_WORD 1
`define TDMRX_IRQ_OVERRUN 2
`define TDMRX_IRQ_DONE 3
`define TDMRX_IRQSEL_WORD 2'h0
`define TDMRX_IRQSEL_FSYNC 2'h2

`endif

// >>> shared/tdmrx_pkg.sv
/*
 * types shared by the tdm serial frame receiver.
 * assumes: nothing beyond a systemverilog compiler.
 */
package tdmrx_pkg;

   typedef enum logic [1:0] {
      ST_HALT,
      ST_WAIT,
      ST_RUN,
      ST_DONE
   } tdmrx_state_type;

   // element length in bits from the word length code
   function automatic logic [5:0] tdmrx_word_bits(input logic [2:0] code);
      case (code)
         3'h1: tdmrx_word_bits = 6'h0C;
         3'h2: tdmrx_word_bits = 6'h10;
         3'h3: tdmrx_word_bits = 6'h14;
         3'h4: tdmrx_word_bits = 6'h18;
         3'h5: tdmrx_word_bits = 6'h20;
         default: tdmrx_word_bits = 6'h08;
      endcase
   endfunction

endpackage

// >>> verilog/tdmrx_pin_sync.sv
/*
 * two-flop synchroniser for the pins of the serial bus.
 * assumes: pins are asynchronous to sys_clk; clk_en freezes the chain.
 */
`timescale 1ns/1ps
`default_nettype none

module tdmrx_pin_sync #(
   parameter int WIDTH = 3
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [WIDTH-1:0] pins_in,
   output logic [WIDTH-1:0] pins_out
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] stable_reg;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         meta_reg <= '0;
         stable_reg <= '0;
      end else if (clk_en) begin
         meta_reg <= pins_in;
         stable_reg <= meta_reg;
      end
   end

   assign pins_out = stable_reg;

endmodule // tdmrx_pin_sync

`default_nettype wire

// >>> tb/tdmrx_bus_model.sv
/*
 * model of the telecom bus device: sources the bit clock, the active-low
 * frame pulse and msb-first serial data, 32 elements of 8 bits per frame.
 * assumes: 160 ns bit clock; data changes on the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none

module tdmrx_bus_model (
   output var logic ext_clock_pin,
   output var logic recv_sync_pin,
   output var logic serial_data_in
);
   initial begin
      ext_clock_pin = 1'b0;
      recv_sync_pin = 1'b1;
      serial_data_in = 1'b0;
   end

   // back-to-back frames; the pulse is low half a period around the rising edge
   task automatic send_frames(input int n);
      logic [7:0] b;
      #7;
      for (int f = 0; f < n; f++) begin
         for (int e = 0; e < 32; e++) begin
            b = {f[2:0], e[4:0]} ^ 8'h5A;
            for (int i = 7; i >= 0; i--) begin
               #40 ext_clock_pin = 1'b0;
               serial_data_in = b[i];
               #40 recv_sync_pin = !(e == 0 && i == 7);
               #40 ext_clock_pin = 1'b1;
               #40 recv_sync_pin = 1'b1;
            end
         end
      end
      serial_data_in = ~serial_data_in;
   endtask
endmodule // tdmrx_bus_model

`default_nettype wire

// >>> tb/testbench.sv
/*
 * self-checking bench of the tdm serial frame receiver.
 * assumes: register port with one-cycle strobes; bus model drives the pins.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic sys_clk, sys_rst, reg_wr, reg_rd, dma, irq, sync_o, clk_oe, sync_oe, clk_o, clk_en;
   logic ext_clk, sync_pin, sdata;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic [7:0] rst_addrs [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
                                  8'h20, 8'h30};
   int miscompares = 0, n_compared = 0, sync_len = 0, dma_seen = 0, n;

   tdmrx_receiver u_tdmrx_receiver (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .ext_clock_pin(ext_clk), .recv_sync_pin(sync_pin), .serial_data_in(sdata),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .cpu_irq_line_fifteen(irq), .recv_dma_event(dma),
      .recv_clock_pin_o(clk_o), .recv_clock_pin_oe(clk_oe), .recv_sync_pin_o(sync_o),
      .recv_sync_pin_oe(sync_oe));
   tdmrx_bus_model u_tdmrx_bus_model (.ext_clock_pin(ext_clk), .recv_sync_pin(sync_pin),
      .serial_data_in(sdata));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic check(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask

   task automatic wait_for(input int lim, input string what);
      n = 0;
      while (((what == "irq") ? irq : dma) !== 1'b1 && n < lim) begin
         @(posedge sys_clk);
         #1 n++;
      end
      check(((what == "irq") ? irq : dma) === 1'b1, what);
   endtask

   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // internal sync must span exactly one bit clock, eight system clocks
   always @(posedge sys_clk) begin
      if (dma === 1'b1) dma_seen <= dma_seen + 1;
      if (sync_o === 1'b1) begin
         sync_len <= sync_len + 1;
      end else if (sync_len != 0) begin
         check(sync_len == 8, "sync width");
         sync_len <= 0;
      end
   end

   initial begin
      #400000;
      miscompares++;
      results;
   end

   initial begin
      sys_rst = 1'b1;
      clk_en = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h00000000;
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      foreach (rst_addrs[i]) begin
         rd(rst_addrs[i], d);
         check(d === 32'h00000000, "reset or unmapped value");
      end
      wr(8'h00, 32'hFFFC1F1F);
      wr(8'h04, 32'h00C00020);
      wr(8'h08, 32'h80000000);
      wr(8'h0C, 32'h00000504);
      wr(8'h1C, 32'h00000001);
      wr(8'h20, 32'h00000002);
      rd(8'h00, d);
      check(d === 32'h00001F00, "receive control readback");
      rd(8'h0C, d);
      check(d === 32'h00000504 && clk_oe === 1'b1 && sync_oe === 1'b0, "pins");
      fork
         u_tdmrx_bus_model.send_frames(4);
      join_none
      wait_for(3000, "irq");
      // the bit clock is 4 system clocks high, 4 low: 4 changes in 16 cycles
      n = 0;
      d[0] = clk_o;
      repeat (16) begin
         @(posedge sys_clk);
         #1 n += (clk_o !== d[0]);
         d[0] = clk_o;
      end
      check(n == 4, "receive clock copy");
      check(dma_seen == 0, "no word while held");
      wr(8'h1C, 32'h00000000);
      rd(8'h14, d);
      check(d[0] === 1'b1 && irq === 1'b0, "masked status");
      wr(8'h18, 32'h00000001);
      rd(8'h14, d);
      check(d[0] === 1'b0, "status clear");
      wr(8'h04, 32'h00C00021);
      for (int f = 1; f < 3; f++) begin
         for (int e = 0; e < 32; e++) begin
            // the first word waits for the whole rest of the current frame
            wait_for((f == 1 && e == 0) ? 2300 : 300, "dma");
            rd(8'h10, d);
            check(d[7:0] === ({f[2:0], e[4:0]} ^ 8'h5A), "element");
         end
      end
      dma_seen = 0;
      repeat (2200) @(posedge sys_clk);
      check(dma_seen == 0, "stopped after target");
      rd(8'h24, d);
      check(d === 32'h00000002, "frame count");
      wr(8'h1C, 32'h00000008);
      rd(8'h14, d);
      check(d[3] === 1'b1 && irq === 1'b1, "done irq");
      wr(8'h18, 32'h00000008);
      rd(8'h14, d);
      check(d[3] === 1'b0 && irq === 1'b0, "done cleared");
      // a write strobe while the clock enable is low must be ignored
      @(posedge sys_clk);
      clk_en <= 1'b0;
      wr(8'h20, 32'h0000000F);
      clk_en <= 1'b1;
      rd(8'h20, d);
      check(d === 32'h00000002, "write ignored while frozen");
      results;
   end
endmodule // testbench

`default_nettype wire
